// ---- pkg/ir_pwm_pkg.sv ----
package ir_pwm_pkg;
  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [3:0] ADDR_IR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CNT_CTRL = 4'h1;
  localparam logic [3:0] ADDR_TMR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_CARRIER = 4'h3;
  localparam logic [3:0] ADDR_HIGH = 4'h4;
  localparam logic [3:0] ADDR_LOW = 4'h5;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h6;
  localparam logic [3:0] ADDR_INT_MASK = 4'h7;
  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int IRC_ENABLE = 0;
  localparam int IRC_CARRIER = 1;
  localparam int IRC_LOWONLY = 2;
  localparam int IRC_ACTIVE = 3;
  localparam int CTL_SRC = 3;
  localparam int INT_HIGH = 0;
  localparam int INT_LOW = 1;
  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PRESET = 8'hff;
endpackage

// ---- rtl/ir_carrier_pwm_generator.sv ----
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module ir_carrier_pwm_generator (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sub_clock_in,
  input wire logic [3:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  output logic ir_output_pin,
  output logic high_underflow_flag,
  output logic low_underflow_flag
);
  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  // Counter and timer control bytes: [2:0] prescale code 2**n, [3] source (0 main, 1 sub)
  logic [7:0] ir_control_setting_reg, ir_control_setting_next;
  logic [7:0] counter_control_setting_reg, counter_control_setting_next;
  logic [7:0] width_timer_control_setting_reg;
  logic [7:0] width_timer_control_setting_next;
  logic [7:0] carrier_preset_reg, carrier_preset_next;
  logic [7:0] high_width_preset_reg, high_width_preset_next;
  logic [7:0] low_width_preset_reg, low_width_preset_next;
  logic [1:0] interrupt_status_register_reg;
  logic [1:0] interrupt_status_register_next;
  logic [1:0] interrupt_mask_register_reg, interrupt_mask_register_next;
  logic [7:0] read_data_reg, read_data_next;
  logic sub_sync1_reg, sub_sync2_reg, sub_sync3_reg;
  logic [7:0] cpre_reg, cpre_next, tpre_reg, tpre_next;
  logic [7:0] carrier_cnt_reg, carrier_cnt_next;
  logic carrier_wave_reg, carrier_wave_next;
  logic [7:0] width_cnt_reg, width_cnt_next;
  logic high_phase_reg, high_phase_next;
  logic active_reg, active_next;
  logic out_reg, out_next;
  logic sub_tick;
  logic carrier_tick, width_tick;
  logic high_uf, low_uf;
  logic enable_bit, carrier_select, low_timer_only_select;

  // Prescaler tick: true when the low code bits of the count are all 1
  function automatic logic pre_done(input logic [7:0] cnt,
                                    input logic [2:0] code);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(code)) begin
        m[i] = 1'b1;
      end
    end
    return (cnt & m) == m;
  endfunction

  // --------------------------------------------------------------------
  // Sub clock synchroniser and edge detect
  // --------------------------------------------------------------------
  // Sub clock is an asynchronous pin, so it passes two flops before its rising edge is detected
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sub_sync1_reg <= 1'b0;
      sub_sync2_reg <= 1'b0;
      sub_sync3_reg <= 1'b0;
    end else begin
      sub_sync1_reg <= sub_clock_in;
      sub_sync2_reg <= sub_sync1_reg;
      sub_sync3_reg <= sub_sync2_reg;
    end
  end
  assign sub_tick = sub_sync2_reg & ~sub_sync3_reg;

  assign enable_bit = ir_control_setting_reg[ir_pwm_pkg::IRC_ENABLE];
  assign carrier_select = ir_control_setting_reg[ir_pwm_pkg::IRC_CARRIER];
  assign low_timer_only_select =
    ir_control_setting_reg[ir_pwm_pkg::IRC_LOWONLY];

  // --------------------------------------------------------------------
  // Clock selection and prescalers
  // --------------------------------------------------------------------
  logic c_src_tick, t_src_tick;
  always_comb begin
    c_src_tick = counter_control_setting_reg[ir_pwm_pkg::CTL_SRC] ?
                 sub_tick : 1'b1;
    t_src_tick = width_timer_control_setting_reg[ir_pwm_pkg::CTL_SRC] ?
                 sub_tick : 1'b1;
    cpre_next = cpre_reg;
    tpre_next = tpre_reg;
    if (!active_reg) begin
      cpre_next = 8'h00;
      tpre_next = 8'h00;
    end else begin
      if (c_src_tick) begin
        cpre_next = cpre_reg + 8'h01;
      end
      if (t_src_tick) begin
        tpre_next = tpre_reg + 8'h01;
      end
    end
    carrier_tick = active_reg & c_src_tick &
                   pre_done(cpre_reg, counter_control_setting_reg[2:0]);
    width_tick = active_reg & t_src_tick &
                 pre_done(tpre_reg, width_timer_control_setting_reg[2:0]);
  end

  // --------------------------------------------------------------------
  // Carrier counter
  // --------------------------------------------------------------------
  always_comb begin
    carrier_cnt_next = carrier_cnt_reg;
    carrier_wave_next = carrier_wave_reg;
    if (!active_reg) begin
      carrier_cnt_next = carrier_preset_reg;
      carrier_wave_next = 1'b0;
    end else if (carrier_tick) begin
      if (carrier_cnt_reg == 8'h00) begin
        carrier_cnt_next = carrier_preset_reg;
        carrier_wave_next = ~carrier_wave_reg;
      end else begin
        carrier_cnt_next = carrier_cnt_reg - 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Width timers and phase sequencing
  // --------------------------------------------------------------------
  // One down counter serves both phases; it reloads with the preset of
  // the phase that follows, so each phase runs preset+1 ticks.
  always_comb begin
    width_cnt_next = width_cnt_reg;
    high_phase_next = high_phase_reg;
    active_next = active_reg;
    high_uf = 1'b0;
    low_uf = 1'b0;
    if (!active_reg) begin
      if (enable_bit) begin
        active_next = 1'b1;
        high_phase_next = ~low_timer_only_select;
        width_cnt_next = low_timer_only_select ? low_width_preset_reg :
                         high_width_preset_reg;
      end
    end else if (width_tick) begin
      if (width_cnt_reg != 8'h00) begin
        width_cnt_next = width_cnt_reg - 8'h01;
      end else if (high_phase_reg) begin
        high_uf = 1'b1;
        if (!enable_bit) begin
          active_next = 1'b0;
        end else begin
          high_phase_next = 1'b0;
          width_cnt_next = low_width_preset_reg;
        end
      end else begin
        low_uf = 1'b1;
        if (low_timer_only_select) begin
          // High timer is skipped entirely
          active_next = enable_bit;
          width_cnt_next = low_width_preset_reg;
        end else begin
          high_phase_next = 1'b1;
          width_cnt_next = high_width_preset_reg;
        end
      end
    end
    if (!active_reg) begin
      out_next = 1'b0;
    end else if (high_phase_next) begin
      out_next = active_next;
    end else if (!active_next) begin
      out_next = 1'b0;
    end else begin
      out_next = carrier_select ? carrier_wave_next : 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  always_comb begin
    ir_control_setting_next = ir_control_setting_reg;
    counter_control_setting_next = counter_control_setting_reg;
    width_timer_control_setting_next = width_timer_control_setting_reg;
    carrier_preset_next = carrier_preset_reg;
    high_width_preset_next = high_width_preset_reg;
    low_width_preset_next = low_width_preset_reg;
    interrupt_mask_register_next = interrupt_mask_register_reg;
    interrupt_status_register_next = interrupt_status_register_reg;
    read_data_next = 8'h00;
    if (write_strobe) begin
      unique case (address)
        ir_pwm_pkg::ADDR_IR_CTRL: ir_control_setting_next = write_data;
        ir_pwm_pkg::ADDR_CNT_CTRL: counter_control_setting_next = write_data;
        ir_pwm_pkg::ADDR_TMR_CTRL:
          width_timer_control_setting_next = write_data;
        ir_pwm_pkg::ADDR_CARRIER: carrier_preset_next = write_data;
        ir_pwm_pkg::ADDR_HIGH: high_width_preset_next = write_data;
        ir_pwm_pkg::ADDR_LOW: low_width_preset_next = write_data;
        // Write 1 clears a flag
        ir_pwm_pkg::ADDR_INT_STATUS:
          interrupt_status_register_next =
            interrupt_status_register_reg & ~write_data[1:0];
        ir_pwm_pkg::ADDR_INT_MASK:
          interrupt_mask_register_next = write_data[1:0];
        default: ;
      endcase
    end
    // Set after clear so a same-cycle event wins
    if (high_uf && interrupt_mask_register_reg[ir_pwm_pkg::INT_HIGH]) begin
      interrupt_status_register_next[ir_pwm_pkg::INT_HIGH] = 1'b1;
    end
    if (low_uf && interrupt_mask_register_reg[ir_pwm_pkg::INT_LOW]) begin
      interrupt_status_register_next[ir_pwm_pkg::INT_LOW] = 1'b1;
    end
    if (read_strobe) begin
      unique case (address)
        ir_pwm_pkg::ADDR_IR_CTRL: begin
          read_data_next = ir_control_setting_reg;
          read_data_next[ir_pwm_pkg::IRC_ACTIVE] = active_reg;
        end
        ir_pwm_pkg::ADDR_CNT_CTRL:
          read_data_next = counter_control_setting_reg;
        ir_pwm_pkg::ADDR_TMR_CTRL:
          read_data_next = width_timer_control_setting_reg;
        ir_pwm_pkg::ADDR_CARRIER: read_data_next = carrier_preset_reg;
        ir_pwm_pkg::ADDR_HIGH: read_data_next = high_width_preset_reg;
        ir_pwm_pkg::ADDR_LOW: read_data_next = low_width_preset_reg;
        ir_pwm_pkg::ADDR_INT_STATUS:
          read_data_next = {6'h00, interrupt_status_register_reg};
        ir_pwm_pkg::ADDR_INT_MASK:
          read_data_next = {6'h00, interrupt_mask_register_reg};
        default: read_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ir_control_setting_reg <= ir_pwm_pkg::RST_BYTE;
      counter_control_setting_reg <= ir_pwm_pkg::RST_BYTE;
      width_timer_control_setting_reg <= ir_pwm_pkg::RST_BYTE;
      carrier_preset_reg <= ir_pwm_pkg::RST_PRESET;
      high_width_preset_reg <= ir_pwm_pkg::RST_PRESET;
      low_width_preset_reg <= ir_pwm_pkg::RST_PRESET;
      interrupt_status_register_reg <= 2'h0;
      interrupt_mask_register_reg <= 2'h0;
      read_data_reg <= ir_pwm_pkg::RST_BYTE;
      cpre_reg <= ir_pwm_pkg::RST_BYTE;
      tpre_reg <= ir_pwm_pkg::RST_BYTE;
      carrier_cnt_reg <= ir_pwm_pkg::RST_BYTE;
      carrier_wave_reg <= 1'b0;
      width_cnt_reg <= ir_pwm_pkg::RST_BYTE;
      high_phase_reg <= 1'b0;
      active_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      ir_control_setting_reg <= ir_control_setting_next;
      counter_control_setting_reg <= counter_control_setting_next;
      width_timer_control_setting_reg <= width_timer_control_setting_next;
      carrier_preset_reg <= carrier_preset_next;
      high_width_preset_reg <= high_width_preset_next;
      low_width_preset_reg <= low_width_preset_next;
      interrupt_status_register_reg <= interrupt_status_register_next;
      interrupt_mask_register_reg <= interrupt_mask_register_next;
      read_data_reg <= read_data_next;
      cpre_reg <= cpre_next;
      tpre_reg <= tpre_next;
      carrier_cnt_reg <= carrier_cnt_next;
      carrier_wave_reg <= carrier_wave_next;
      width_cnt_reg <= width_cnt_next;
      high_phase_reg <= high_phase_next;
      active_reg <= active_next;
      out_reg <= out_next;
    end
  end

  assign read_data = read_data_reg;
  assign ir_output_pin = out_reg;
  assign high_underflow_flag =
    interrupt_status_register_reg[ir_pwm_pkg::INT_HIGH];
  assign low_underflow_flag =
    interrupt_status_register_reg[ir_pwm_pkg::INT_LOW];
endmodule // ir_carrier_pwm_generator

// ---- testbench/ir_load_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Emitter load: measures the pulse runs seen on the output pin
// ----------------------------------------------------------------------
module ir_load_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic pin,
  input wire logic clear,
  output logic [15:0] high_len,
  output logic [15:0] max_low
);
  logic [15:0] run;
  logic prev;
  // Runs are counted in main clock cycles; a clear drops the partial run and zeroes high_len and max_low
  // so a stale idle stretch never counts as a low phase
  always_ff @(posedge clock) begin
    prev <= pin;
    if (!rstn || clear) begin
      run <= 16'h0000;
      high_len <= 16'h0000;
      max_low <= 16'h0000;
    end else if (pin == prev) begin
      run <= run + 16'h0001;
    end else begin
      if (prev) begin
        high_len <= run;
      end else if (run > max_low) begin
        max_low <= run;
      end
      run <= 16'h0001;
    end
  end
endmodule // ir_load_model

// ---- testbench/ir_carrier_pwm_generator_assertions.sv ----
`timescale 1ns/100ps
module ir_pwm_checker (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sub_clock_in,
  input wire logic [3:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [7:0] read_data,
  input wire logic ir_output_pin,
  input wire logic high_underflow_flag,
  input wire logic low_underflow_flag
);
  logic low_only_reg;
  // Shadow of the low-only bit, taken from the register writes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      low_only_reg <= 1'b0;
    end else if (write_strobe && address == ir_pwm_pkg::ADDR_IR_CTRL) begin
      low_only_reg <= write_data[ir_pwm_pkg::IRC_LOWONLY];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_reset_quiet;
    disable iff (1'b0) !rstn |=> !ir_output_pin && !high_underflow_flag &&
      !low_underflow_flag && read_data == 8'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("busy in reset");
  property p_rd_idle;
    !$past(read_strobe) |-> read_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("stray read data");
  property p_rd_status;
    read_strobe && address == ir_pwm_pkg::ADDR_INT_STATUS |=> read_data ==
      {6'h00, $past(low_underflow_flag), $past(high_underflow_flag)};
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("bad status");
  property p_unmapped;
    read_strobe && address > 4'h7 |=> read_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read");
  property p_hclear;
    $past(rstn) && $fell(high_underflow_flag) |-> $past(write_strobe &&
      address == ir_pwm_pkg::ADDR_INT_STATUS && write_data[0]);
  endproperty
  a_hclear: assert property (p_hclear)
    else $error("high flag lost");
  property p_lclear;
    $past(rstn) && $fell(low_underflow_flag) |-> $past(write_strobe &&
      address == ir_pwm_pkg::ADDR_INT_STATUS && write_data[1]);
  endproperty
  a_lclear: assert property (p_lclear)
    else $error("low flag lost");
  property p_distinct;
    !($rose(high_underflow_flag) && $rose(low_underflow_flag));
  endproperty
  a_distinct: assert property (p_distinct)
    else $error("flags merged");
  property p_lowonly;
    low_only_reg |-> !$rose(high_underflow_flag);
  endproperty
  a_lowonly: assert property (p_lowonly)
    else $error("high timer ran");
endmodule // ir_pwm_checker
bind ir_carrier_pwm_generator ir_pwm_checker ir_pwm_checker_i (
  .clock(clock), .rstn(rstn), .sub_clock_in(sub_clock_in),
  .address(address), .write_data(write_data), .write_strobe(write_strobe),
  .read_strobe(read_strobe), .read_data(read_data),
  .ir_output_pin(ir_output_pin), .high_underflow_flag(high_underflow_flag),
  .low_underflow_flag(low_underflow_flag));

// ---- testbench/test_ir_carrier_pwm_generator.sv ----
`timescale 1ns/100ps
module test_ir_carrier_pwm_generator;
  logic clock, rstn, sub_clock_in, write_strobe, read_strobe, clear;
  logic [3:0] address;
  logic [7:0] write_data, read_data;
  logic ir_output_pin, high_underflow_flag, low_underflow_flag;
  logic [15:0] high_len, max_low;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  ir_carrier_pwm_generator ir_carrier_pwm_generator_i (.clock(clock),
    .rstn(rstn), .sub_clock_in(sub_clock_in), .address(address),
    .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data),
    .ir_output_pin(ir_output_pin), .high_underflow_flag(high_underflow_flag),
    .low_underflow_flag(low_underflow_flag));
  ir_load_model ir_load_model_i (.clock(clock), .rstn(rstn),
    .pin(ir_output_pin), .clear(clear), .high_len(high_len),
    .max_low(max_low));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Sub oscillator: one rising edge every 16 main cycles
  initial begin
    sub_clock_in = 1'b0;
    forever begin
      repeat (8) @(posedge clock);
      sub_clock_in <= ~sub_clock_in;
    end
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    write_strobe <= 1'b1;
    address <= a;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    read_strobe <= 1'b1;
    address <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 check("read_data", {8'h00, read_data}, {8'h00, exp});
  endtask
  // Bounded wait for a pin level; a hang shows up as a mismatch
  task automatic wait_pin(input logic v);
    int i;
    i = 0;
    while (ir_output_pin !== v && i < 3000) begin
      @(posedge clock);
      #1 i++;
    end
    check("ir_output_pin", {15'h0000, ir_output_pin}, {15'h0000, v});
  endtask
  task automatic clr_model();
    @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    address = 4'h0;
    write_data = 8'h00;
    clear = 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    for (int a = 0; a < 9; a++) rd(a[3:0], (a > 2 && a < 6) ?
      ir_pwm_pkg::RST_PRESET : ir_pwm_pkg::RST_BYTE);
    $display("test reset values done");
    wr(ir_pwm_pkg::ADDR_INT_MASK, 8'h01);
    wr(ir_pwm_pkg::ADDR_TMR_CTRL, 8'h01);
    wr(ir_pwm_pkg::ADDR_HIGH, 8'h03);
    wr(ir_pwm_pkg::ADDR_LOW, 8'h05);
    wr(ir_pwm_pkg::ADDR_IR_CTRL, 8'h01);
    wait_pin(1'b1);
    clr_model();
    wait_pin(1'b0);
    wait_pin(1'b1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    check("high_len", high_len, 16'h0008);
    check("max_low", max_low, 16'h000c);
    rd(ir_pwm_pkg::ADDR_INT_STATUS, 8'h01);
    check("high_flag", {15'h0000, high_underflow_flag}, 16'h0001);
    wr(ir_pwm_pkg::ADDR_INT_STATUS, 8'h01);
    rd(ir_pwm_pkg::ADDR_INT_STATUS, 8'h00);
    check("high_flag", {15'h0000, high_underflow_flag}, 16'h0000);
    wait_pin(1'b0);
    wr(ir_pwm_pkg::ADDR_IR_CTRL, 8'h00);
    rd(ir_pwm_pkg::ADDR_IR_CTRL, 8'h08);
    wait_pin(1'b1);
    wait_pin(1'b0);
    clr_model();
    repeat (300) @(posedge clock);
    check("high_len", high_len, 16'h0000);
    rd(ir_pwm_pkg::ADDR_IR_CTRL, 8'h00);
    $display("test plain pwm and stop done");
    wr(ir_pwm_pkg::ADDR_CNT_CTRL, 8'h01);
    wr(ir_pwm_pkg::ADDR_CARRIER, 8'h00);
    wr(ir_pwm_pkg::ADDR_LOW, 8'h07);
    wr(ir_pwm_pkg::ADDR_TMR_CTRL, 8'h00);
    wr(ir_pwm_pkg::ADDR_IR_CTRL, 8'h03);
    wait_pin(1'b1);
    clr_model();
    repeat (60) @(posedge clock);
    check("max_low", max_low, 16'h0002);
    wr(ir_pwm_pkg::ADDR_IR_CTRL, 8'h00);
    repeat (100) @(posedge clock);
    $display("test carrier done");
    wr(ir_pwm_pkg::ADDR_INT_MASK, 8'h03);
    wr(ir_pwm_pkg::ADDR_INT_STATUS, 8'h03);
    wr(ir_pwm_pkg::ADDR_IR_CTRL, 8'h05);
    clr_model();
    repeat (100) @(posedge clock);
    check("high_len", high_len, 16'h0000);
    rd(ir_pwm_pkg::ADDR_INT_STATUS, 8'h02);
    check("low_flag", {15'h0000, low_underflow_flag}, 16'h0001);
    wr(ir_pwm_pkg::ADDR_IR_CTRL, 8'h00);
    repeat (50) @(posedge clock);
    $display("test low only done");
    wr(ir_pwm_pkg::ADDR_TMR_CTRL, 8'h08);
    wr(ir_pwm_pkg::ADDR_HIGH, 8'h02);
    wr(ir_pwm_pkg::ADDR_IR_CTRL, 8'h01);
    wait_pin(1'b1);
    wait_pin(1'b0);
    wait_pin(1'b1);
    wait_pin(1'b0);
    // The load model records the run one edge after the pin falls
    repeat (2) @(posedge clock);
    check("high_len", high_len, 16'h0030);
    wr(ir_pwm_pkg::ADDR_IR_CTRL, 8'h00);
    $display("test sub clock source done");
    give_verdict();
  end
endmodule // test_ir_carrier_pwm_generator
